// [design/dais_consts.svh]
// constants for the dual register-unit issue scheduler
`ifndef DAIS_CONSTS_SVH
`define DAIS_CONSTS_SVH
`define DAIS_REG_W 3
`define DAIS_NREG 8
`define DAIS_TAG_W 4
`define DAIS_NTAG 16
`define DAIS_CNT_W 3
`define DAIS_LAT_REG 3'h1
`define DAIS_LAT_LOAD 3'h2
`define DAIS_MUL_DEC_CYC 2
`define DAIS_MUL_UOPS 3
`define DAIS_UNIT_X 0
`define DAIS_UNIT_Y 1
`define DAIS_UNIT_L 2
`define DAIS_UNIT_S 3
`endif

// [design/dais_issue_sched.sv]
// issue and scheduling control for two register units, a load unit and a store unit
`default_nettype none
`include "dais_consts.svh"
// Function
// RL1 - register multiply spends two decode cycles; here a multiply from dec1 skips the second decode cycle
// RL2 - register multiply goes to X only
// RL3 - multiply is three serial uops, low then high; here a multiply from dec1 goes to X as a single uop
// RL4 - load immediate needs no unit, result ready
// RL5 - shifts go to X only
// RL6 - X-only ops wait while multiply holds X
// RL7 - long operand wait bumps, reissue next cycle
// RL8 - following op enters behind bumped op directly
// RL9 - load address operand bypassed without delay
// RL10 - load unit takes one load per clock
// RL11 - load operand fetch waits for all operands
// RL12 - Y-bound op delayed while Y is taken
// RL13 - each unit takes one new op per cycle
// RL14 - results bypass straight to dependent units
// RL15 - store queue forwards to dependent loads; here the load waits while a store is in the store unit
module dais_issue_sched
  import dais_pkg::*;
#(
  parameter int NREG = `DAIS_NREG,
  parameter int NTAG = `DAIS_NTAG
) (
  input wire logic clk, // core clock
  input wire logic arst_n, // async reset, active low
  input wire logic ce, // clock enable, freezes all state when low
  input wire dais_dec_type dec0, // older decoded operation
  input wire dais_dec_type dec1, // younger decoded operation
  output logic decReady, // pair on dec0/dec1 taken at next edge
  output dais_uop_type xExec, // operation entering X execute
  output dais_uop_type yExec, // operation entering Y execute
  output dais_uop_type lExec, // operation entering load execute
  output dais_uop_type sExec, // operation entering store execute
  output logic xBump, // op removed from X operand stage
  output logic yBump, // op removed from Y operand stage
  output logic mulBusy // multiply holds the X unit
);
  if (NREG != `DAIS_NREG || NTAG != `DAIS_NTAG) begin : g_bad_size
    $error("dais_issue_sched: NREG and NTAG must match the field widths");
  end

  dais_dec_type dq_q [2];
  dais_dec_type sk_q [2];
  logic mulDec_q;
  dais_seq_type seq_q;
  dais_uop_type seqUop_q;
  dais_uop_type rq_q [2];
  logic [`DAIS_TAG_W-1:0] nextTag_q;
  logic [`DAIS_TAG_W-1:0] wrTag_q [NREG];
  logic wrValid_q [NREG];
  logic tagExec_q [NTAG];
  logic [`DAIS_CNT_W-1:0] tagCnt_q [NTAG];

  dais_uop_type st [8]; // 0..3 issue stages, 4..7 operand stages
  dais_uop_type stIn [8];
  logic stLoad [8];
  logic stClr [8];
  logic oGo [4];
  logic oBump [2];
  logic iMove [4];
  logic iFree [4];
  dais_uop_type newI [4];
  logic taken [4];
  dais_uop_type cand [5];
  logic candEn [5];
  logic candDone [5];
  dais_uop_type du [2];
  logic [`DAIS_TAG_W-1:0] dTag [2];
  logic dEmptyNext;
  logic take;
  logic storeAhead;
  logic mulBusyNow;
  logic [`DAIS_TAG_W-1:0] allocN;

  // issue and operand stages of the four units
  for (genvar g = 0; g < 8; g++) begin : g_stage
    dais_stage u_stage (
      .clk(clk),
      .arst_n(arst_n),
      .ce(ce),
      .load(stLoad[g]),
      .clear(stClr[g]),
      .inUop(stIn[g]),
      .stUop(st[g])
    );
  end

  // operand ready within a cycle counts as ready through the bypass
  function automatic logic srcOk(input logic w, input logic [`DAIS_TAG_W-1:0] t);
    return !w || (tagExec_q[t] && tagCnt_q[t] <= 3'h1);
  endfunction : srcOk

  // operand more than two cycles away
  function automatic logic srcLate(input logic w, input logic [`DAIS_TAG_W-1:0] t);
    return w && (!tagExec_q[t] || tagCnt_q[t] > 3'h2);
  endfunction : srcLate

  assign storeAhead = st[`DAIS_UNIT_S].valid || st[`DAIS_UNIT_S+4].valid;
  assign mulBusyNow = (seq_q != SEQ_IDLE) || (st[0].mulStep != 2'h0) || (st[4].mulStep != 2'h0);

  // operand stage advance, bump and issue stage movement per unit
  always_comb begin
    for (int u = 0; u < 4; u++) begin
      oGo[u] = st[u+4].valid && srcOk(st[u+4].waitA, st[u+4].tagA)
               && srcOk(st[u+4].waitB, st[u+4].tagB); // [RL9] [RL11] [RL14]
      if (u == `DAIS_UNIT_L && st[u+4].memDep && storeAhead) begin
        oGo[u] = 1'b0; // [RL15]
      end
    end
    for (int u = 0; u < 2; u++) begin
      oBump[u] = st[u+4].valid && !oGo[u] && !rq_q[u].valid
                 && (srcLate(st[u+4].waitA, st[u+4].tagA) || srcLate(st[u+4].waitB, st[u+4].tagB)); // [RL7]
    end
    for (int u = 0; u < 4; u++) begin
      iMove[u] = st[u].valid && (!st[u+4].valid || oGo[u] || (u < 2 && oBump[u[0]])); // [RL8]
      iFree[u] = !st[u].valid || iMove[u];
    end
  end

  // decoded slots turned into tagged operations, younger sees older's tag
  always_comb begin
    allocN = '0;
    dTag[0] = nextTag_q;
    dTag[1] = nextTag_q + ((dq_q[0].cls == CLS_MUL) ? 4'h2 : {3'h0, dq_q[0].hasDest});
    for (int s = 0; s < 2; s++) begin
      du[s] = '0;
      du[s].valid = dq_q[s].valid;
      du[s].cls = dq_q[s].cls;
      du[s].waitA = dq_q[s].useA && wrValid_q[dq_q[s].srcA];
      du[s].tagA = wrTag_q[dq_q[s].srcA];
      du[s].waitB = dq_q[s].useB && wrValid_q[dq_q[s].srcB];
      du[s].tagB = wrTag_q[dq_q[s].srcB];
      du[s].hasDest = dq_q[s].hasDest;
      du[s].tag = dTag[s];
      du[s].memDep = dq_q[s].memDep;
    end
    if (dq_q[0].hasDest && dq_q[0].cls != CLS_MUL) begin
      if (dq_q[1].useA && dq_q[1].srcA == dq_q[0].dest) begin
        du[1].waitA = 1'b1;
        du[1].tagA = dTag[0];
      end
      if (dq_q[1].useB && dq_q[1].srcB == dq_q[0].dest) begin
        du[1].waitB = 1'b1;
        du[1].tagB = dTag[0];
      end
    end
    if (candDone[3]) begin
      allocN = dTag[1] - nextTag_q;
    end
    if (candDone[4] && dq_q[1].hasDest) begin
      allocN = allocN + 4'h1;
    end
  end

  // dispatch: reissued ops first, then multiply uops, then decode in order
  always_comb begin
    // a bumped op is offered again in its bump cycle so it sits in issue the next cycle
    cand[0] = rq_q[0].valid ? rq_q[0] : (oBump[0] ? st[4] : '0); // [RL7]
    cand[1] = rq_q[1].valid ? rq_q[1] : (oBump[1] ? st[5] : '0); // [RL7]
    cand[2] = seqUop_q;
    cand[2].valid = (seq_q != SEQ_IDLE);
    cand[3] = du[0];
    cand[4] = du[1];
    candEn[0] = 1'b1;
    candEn[1] = 1'b1;
    candEn[2] = 1'b1;
    candEn[3] = 1'b1;
    candEn[4] = 1'b0;
    for (int u = 0; u < 4; u++) begin
      newI[u] = '0;
      taken[u] = 1'b0;
    end
    for (int c = 0; c < 5; c++) begin
      candDone[c] = 1'b0;
      if (c == 4) begin
        candEn[4] = (candDone[3] || !du[0].valid) && du[0].cls != CLS_MUL;
      end
      if (cand[c].valid && candEn[c]) begin
        unique case (cand[c].cls)
          CLS_LIMM: begin
            candDone[c] = 1'b1; // [RL4]
          end
          CLS_LOAD, CLS_STORE: begin
            if (cand[c].cls == CLS_LOAD && iFree[`DAIS_UNIT_L] && !taken[`DAIS_UNIT_L]) begin
              newI[`DAIS_UNIT_L] = cand[c]; // [RL10]
              taken[`DAIS_UNIT_L] = 1'b1; // [RL13]
              candDone[c] = 1'b1;
            end else if (cand[c].cls == CLS_STORE && iFree[`DAIS_UNIT_S] && !taken[`DAIS_UNIT_S]) begin
              newI[`DAIS_UNIT_S] = cand[c];
              taken[`DAIS_UNIT_S] = 1'b1; // [RL13]
              candDone[c] = 1'b1;
            end
          end
          CLS_ALU: begin
            if (iFree[`DAIS_UNIT_X] && !taken[`DAIS_UNIT_X]) begin
              newI[`DAIS_UNIT_X] = cand[c]; // [RL7]
              taken[`DAIS_UNIT_X] = 1'b1;
              candDone[c] = 1'b1;
            end else if (iFree[`DAIS_UNIT_Y] && !taken[`DAIS_UNIT_Y]) begin
              newI[`DAIS_UNIT_Y] = cand[c]; // [RL12]
              taken[`DAIS_UNIT_Y] = 1'b1; // [RL13]
              candDone[c] = 1'b1;
            end
          end
          CLS_ALUX, CLS_SHIFT, CLS_MUL: begin
            if (c == 3 && cand[c].cls == CLS_MUL) begin
              if (mulDec_q && !mulBusyNow && iFree[`DAIS_UNIT_X] && !taken[`DAIS_UNIT_X]) begin
                newI[`DAIS_UNIT_X] = cand[c]; // [RL1] [RL2]
                newI[`DAIS_UNIT_X].hasDest = 1'b0;
                newI[`DAIS_UNIT_X].mulStep = 2'h1; // [RL3]
                taken[`DAIS_UNIT_X] = 1'b1;
                candDone[c] = 1'b1;
              end
            end else if (iFree[`DAIS_UNIT_X] && !taken[`DAIS_UNIT_X]
                         && (cand[c].mulStep != 2'h0 || !mulBusyNow)) begin
              newI[`DAIS_UNIT_X] = cand[c]; // [RL2] [RL5] [RL6]
              taken[`DAIS_UNIT_X] = 1'b1;
              candDone[c] = 1'b1;
            end
          end
          default: begin
            candDone[c] = 1'b1;
          end
        endcase
      end
    end
  end

  // stage controls: a stage refills in the cycle it passes its op on
  always_comb begin
    for (int u = 0; u < 4; u++) begin
      stIn[u] = newI[u];
      stLoad[u] = newI[u].valid;
      stClr[u] = iMove[u];
      stIn[u+4] = st[u];
      stLoad[u+4] = iMove[u];
      stClr[u+4] = oGo[u] || (u < 2 && oBump[u[0]]); // [RL7]
    end
  end

  assign dEmptyNext = (!dq_q[0].valid || candDone[3]) && (!dq_q[1].valid || candDone[4]);
  assign take = decReady && (dec0.valid || dec1.valid);

  // decode holding slots with a skid pair so the decoder can stream
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dq_q[0] <= '0;
      dq_q[1] <= '0;
      sk_q[0] <= '0;
      sk_q[1] <= '0;
      decReady <= 1'b1;
    end else if (ce) begin
      if (dEmptyNext) begin
        dq_q[0] <= (sk_q[0].valid || sk_q[1].valid) ? sk_q[0] : (take ? dec0 : '0);
        dq_q[1] <= (sk_q[0].valid || sk_q[1].valid) ? sk_q[1] : (take ? dec1 : '0);
      end else begin
        if (candDone[3]) begin
          dq_q[0] <= '0;
        end
        if (candDone[4]) begin
          dq_q[1] <= '0;
        end
      end
      if (take && !(dEmptyNext && !(sk_q[0].valid || sk_q[1].valid))) begin
        sk_q[0] <= dec0;
        sk_q[1] <= dec1;
        decReady <= 1'b0;
      end else if (dEmptyNext) begin
        sk_q[0] <= '0;
        sk_q[1] <= '0;
        decReady <= 1'b1;
      end
    end
  end

  // second decode cycle of a multiply
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mulDec_q <= 1'b0;
    end else if (ce) begin
      mulDec_q <= dq_q[0].valid && dq_q[0].cls == CLS_MUL && !candDone[3]; // [RL1]
    end
  end

  // multiply sequencer: first uop leaves the decode slot, then low result, then high
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      seq_q <= SEQ_IDLE;
      seqUop_q <= '0;
    end else if (ce) begin
      unique case (seq_q)
        SEQ_IDLE: begin
          if (candDone[3] && du[0].cls == CLS_MUL) begin
            seqUop_q <= du[0];
            seqUop_q.hasDest <= 1'b1;
            seqUop_q.mulStep <= 2'h2;
            seq_q <= SEQ_U2; // [RL3]
          end
        end
        SEQ_U1: begin
          if (candDone[2]) begin
            seqUop_q.hasDest <= 1'b1;
            seqUop_q.mulStep <= 2'h2;
            seq_q <= SEQ_U2; // [RL3]
          end
        end
        SEQ_U2: begin
          if (candDone[2]) begin
            seqUop_q.tag <= seqUop_q.tag + 4'h1;
            seqUop_q.mulStep <= 2'h3;
            seq_q <= SEQ_U3; // [RL3]
          end
        end
        SEQ_U3: begin
          if (candDone[2]) begin
            seq_q <= SEQ_IDLE;
          end
        end
      endcase
    end
  end

  // reissue holders keep a bumped op that found no free issue stage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rq_q[0] <= '0;
      rq_q[1] <= '0;
    end else if (ce) begin
      for (int u = 0; u < 2; u++) begin
        if (oBump[u] && !candDone[u]) begin
          rq_q[u] <= st[u+4]; // [RL7]
        end else if (candDone[u]) begin
          rq_q[u] <= '0;
        end
      end
    end
  end

  // result scoreboard: tags count down to availability at the bypass
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      nextTag_q <= '0;
      for (int r = 0; r < NREG; r++) begin
        wrTag_q[r] <= '0;
        wrValid_q[r] <= 1'b0;
      end
      for (int t = 0; t < NTAG; t++) begin
        tagExec_q[t] <= 1'b1;
        tagCnt_q[t] <= '0;
      end
    end else if (ce) begin
      nextTag_q <= nextTag_q + allocN;
      for (int t = 0; t < NTAG; t++) begin
        if (tagCnt_q[t] != '0) begin
          tagCnt_q[t] <= tagCnt_q[t] - 3'h1;
        end
      end
      for (int u = 0; u < 4; u++) begin
        if (oGo[u] && st[u+4].hasDest) begin
          tagExec_q[st[u+4].tag] <= 1'b1; // [RL14]
          tagCnt_q[st[u+4].tag] <= (u == `DAIS_UNIT_L) ? `DAIS_LAT_LOAD : `DAIS_LAT_REG;
        end
      end
      for (int s = 0; s < 2; s++) begin
        if (candDone[s+3] && (dq_q[s].hasDest || dq_q[s].cls == CLS_MUL)) begin
          wrTag_q[dq_q[s].dest] <= dTag[s];
          wrValid_q[dq_q[s].dest] <= 1'b1;
          tagExec_q[dTag[s]] <= (dq_q[s].cls == CLS_LIMM); // [RL4]
          tagCnt_q[dTag[s]] <= '0;
          if (dq_q[s].cls == CLS_MUL) begin
            wrTag_q[dq_q[s].destHi] <= dTag[s] + 4'h1;
            wrValid_q[dq_q[s].destHi] <= 1'b1;
            tagExec_q[dTag[s] + 4'h1] <= 1'b0; // [RL3]
          end
        end
      end
    end
  end

  // execute entry, bump pulses and multiply occupancy outputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      xExec <= '0;
      yExec <= '0;
      lExec <= '0;
      sExec <= '0;
      xBump <= 1'b0;
      yBump <= 1'b0;
      mulBusy <= 1'b0;
    end else if (ce) begin
      xExec <= oGo[0] ? st[4] : '0;
      yExec <= oGo[1] ? st[5] : '0;
      lExec <= oGo[2] ? st[6] : '0;
      sExec <= oGo[3] ? st[7] : '0;
      xBump <= oBump[0];
      yBump <= oBump[1];
      mulBusy <= mulBusyNow;
    end
  end
endmodule : dais_issue_sched
`default_nettype wire

// [design/dais_pkg.sv]
// types shared by the issue scheduler files
`default_nettype none
package dais_pkg;
`include "dais_consts.svh"
  typedef enum logic [2:0] {
    CLS_ALU = 3'h0, CLS_ALUX = 3'h1, CLS_SHIFT = 3'h2, CLS_MUL = 3'h3,
    CLS_LIMM = 3'h4, CLS_LOAD = 3'h5, CLS_STORE = 3'h6
  } dais_cls_type;
  // one decoded operation as the decoder presents it
  typedef struct packed {
    logic valid;
    dais_cls_type cls;
    logic useA;
    logic [`DAIS_REG_W-1:0] srcA;
    logic useB;
    logic [`DAIS_REG_W-1:0] srcB;
    logic hasDest;
    logic [`DAIS_REG_W-1:0] dest;
    logic [`DAIS_REG_W-1:0] destHi;
    logic memDep;
  } dais_dec_type;
  // an operation inside the unit pipes, operands named by producer tag
  typedef struct packed {
    logic valid;
    dais_cls_type cls;
    logic waitA;
    logic [`DAIS_TAG_W-1:0] tagA;
    logic waitB;
    logic [`DAIS_TAG_W-1:0] tagB;
    logic hasDest;
    logic [`DAIS_TAG_W-1:0] tag;
    logic memDep;
    logic [1:0] mulStep;
  } dais_uop_type;
  typedef enum logic [3:0] {
    SEQ_IDLE = 4'b0001, SEQ_U1 = 4'b0010, SEQ_U2 = 4'b0100, SEQ_U3 = 4'b1000
  } dais_seq_type;
endpackage : dais_pkg
`default_nettype wire

// [design/dais_stage.sv]
// one pipe stage register holding an operation
`default_nettype none
module dais_stage
  import dais_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic arst_n, // async reset
  input wire logic ce, // clock enable
  input wire logic load, // take inUop
  input wire logic clear, // empty the stage
  input wire dais_uop_type inUop, // incoming operation
  output dais_uop_type stUop // held operation
);
  // load wins over clear, so a stage can pass on and refill in one cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stUop <= '0;
    end else if (ce) begin
      if (load) begin
        stUop <= inUop;
      end else if (clear) begin
        stUop <= '0;
      end
    end
  end
endmodule : dais_stage
`default_nettype wire

// [verification/dais_dec_model.sv]
// decoder model presenting queued operation pairs
`default_nettype none
module dais_dec_model
  import dais_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic arst_n, // async reset
  input wire logic ce, // clock enable
  input wire logic decReady, // scheduler takes pair
  input wire logic [31:0] cycNow, // bench cycle count
  output dais_dec_type dec0, // older op
  output dais_dec_type dec1 // younger op
);
  dais_dec_type q0[$];
  dais_dec_type q1[$];
  dais_dec_type idle0;
  dais_dec_type idle1;
  int taken[$];
  // queue a pair, older op first
  task automatic push(input dais_dec_type a, input dais_dec_type b);
    q0.push_back(a);
    q1.push_back(b);
  endtask : push
  // hold a pair until taken; idle fields keep changing so nothing stale looks valid
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dec0 <= '0;
      dec1 <= '0;
    end else begin
      if (ce && decReady && (dec0.valid || dec1.valid)) begin
        taken.push_back(int'(cycNow));
        void'(q0.pop_front());
        void'(q1.pop_front());
      end
      idle0 = ~dec0;
      idle1 = ~dec1;
      idle0.valid = 1'h0;
      idle1.valid = 1'h0;
      dec0 <= (q0.size() > 0) ? q0[0] : idle0;
      dec1 <= (q1.size() > 0) ? q1[0] : idle1;
    end
  end
endmodule : dais_dec_model
`default_nettype wire

// [verification/dais_issue_properties.sv]
// concurrent checks on the issue scheduler ports
`default_nettype none
module dais_issue_properties
  import dais_pkg::*;
#(
  parameter int NREG = 8,
  parameter int NTAG = 16
) (
  input wire logic clk, // core clock
  input wire logic arst_n, // async reset
  input wire logic ce, // clock enable
  input wire dais_dec_type dec0, // older op
  input wire dais_dec_type dec1, // younger op
  input wire logic decReady, // pair taken
  input wire dais_uop_type xExec, // x execute
  input wire dais_uop_type yExec, // y execute
  input wire dais_uop_type lExec, // load execute
  input wire dais_uop_type sExec, // store execute
  input wire logic xBump, // x bump pulse
  input wire logic yBump, // y bump pulse
  input wire logic mulBusy // multiply holds x
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // a load-immediate never shows on any unit
  logic limmSeen;
  assign limmSeen = (xExec.valid && xExec.cls == CLS_LIMM) || (yExec.valid && yExec.cls == CLS_LIMM)
    || (lExec.valid && lExec.cls == CLS_LIMM) || (sExec.valid && sExec.cls == CLS_LIMM);
  // the multiply steps follow one another in x
  sequence mulLow;
    ##[1:3] (xExec.valid && xExec.mulStep == 2'h2);
  endsequence
  sequence mulHigh;
    ##[1:3] (xExec.valid && xExec.mulStep == 2'h3);
  endsequence
  chk_mul_x_only: assert property (yExec.valid |-> yExec.cls != CLS_MUL)
    else $error("multiply seen in y");
  chk_xonly_not_y: assert property (yExec.valid |-> !(yExec.cls inside {CLS_SHIFT, CLS_ALUX}))
    else $error("x-only op seen in y");
  chk_limm_no_unit: assert property (!limmSeen)
    else $error("load-immediate used a unit");
  chk_load_unit_cls: assert property (lExec.valid |-> lExec.cls == CLS_LOAD)
    else $error("non-load in load unit");
  chk_mul_first_step: assert property (xExec.valid && xExec.mulStep == 2'h1 |-> !xExec.hasDest)
    else $error("first multiply step writes");
  chk_mul_step_order: assert property (xExec.valid && xExec.mulStep == 2'h1 |-> mulLow ##0 mulHigh)
    else $error("multiply steps out of order");
  chk_mul_busy_start: assert property ($rose(mulBusy) |-> ##[1:8] (xExec.valid && xExec.mulStep == 2'h1))
    else $error("multiply did not start");
  chk_bump_reissue: assert property (xBump || yBump |-> ##[1:4] (xExec.valid || yExec.valid))
    else $error("bumped op not reissued");
  chk_ce_freeze: assert property (!ce |=> $stable(xExec) && $stable(decReady) && $stable(mulBusy))
    else $error("state moved with enable low");
endmodule : dais_issue_properties
bind dais_issue_sched dais_issue_properties #(.NREG(NREG), .NTAG(NTAG)) u_props (.clk(clk), .arst_n(arst_n),
  .ce(ce), .dec0(dec0), .dec1(dec1), .decReady(decReady), .xExec(xExec), .yExec(yExec), .lExec(lExec),
  .sExec(sExec), .xBump(xBump), .yBump(yBump), .mulBusy(mulBusy));
`default_nettype wire

// [verification/dais_issue_sched_bench.sv]
// self-checking bench for the issue scheduler
`default_nettype none
`include "dais_consts.svh"
module dais_issue_sched_bench
  import dais_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {int c; int u; dais_cls_type k; logic [1:0] s;} dais_ev_type;
  logic clk = 1'h0;
  logic arst_n = 1'h0;
  logic ce = 1'h1;
  int cyc = 0;
  int bumps = 0;
  int bad_count = 0;
  int checks_done = 0;
  dais_ev_type evs[$];
  dais_dec_type dec0;
  dais_dec_type dec1;
  dais_uop_type xExec;
  dais_uop_type yExec;
  dais_uop_type lExec;
  dais_uop_type sExec;
  logic decReady;
  logic xBump;
  logic yBump;
  logic mulBusy;
  // 250 MHz core clock
  always #2 clk = ~clk;
  dais_issue_sched u_dais_issue_sched (.clk(clk), .arst_n(arst_n), .ce(ce), .dec0(dec0), .dec1(dec1),
    .decReady(decReady), .xExec(xExec), .yExec(yExec), .lExec(lExec), .sExec(sExec), .xBump(xBump),
    .yBump(yBump), .mulBusy(mulBusy));
  dais_dec_model u_dais_dec_model (.clk(clk), .arst_n(arst_n), .ce(ce), .decReady(decReady),
    .cycNow(cyc), .dec0(dec0), .dec1(dec1));
  // log each op in the cycle it leaves its operand stage for execute
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (xExec.valid) evs.push_back('{cyc - 1, `DAIS_UNIT_X, xExec.cls, xExec.mulStep});
    if (yExec.valid) evs.push_back('{cyc - 1, `DAIS_UNIT_Y, yExec.cls, yExec.mulStep});
    if (lExec.valid) evs.push_back('{cyc - 1, `DAIS_UNIT_L, lExec.cls, lExec.mulStep});
    if (sExec.valid) evs.push_back('{cyc - 1, `DAIS_UNIT_S, sExec.cls, sExec.mulStep});
    if (xBump || yBump) bumps++;
  end
  function automatic dais_dec_type op(dais_cls_type k, int a, int d);
    dais_dec_type o;
    o = '0;
    o.valid = 1'h1;
    o.cls = k;
    o.useA = (a >= 0);
    o.srcA = a[2:0];
    o.hasDest = (d >= 0);
    o.dest = d[2:0];
    o.destHi = 3'h7;
    return o;
  endfunction : op
  // n-th logged op of a class and step
  function automatic dais_ev_type ev(dais_cls_type k, logic [1:0] s, int n);
    int m;
    m = 0;
    foreach (evs[i]) begin
      if (evs[i].k == k && evs[i].s == s) begin
        if (m == n) return evs[i];
        m++;
      end
    end
    return '{-99, -1, k, s};
  endfunction : ev
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %0d expected %0d", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    if (bad_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic begin_scen();
    #1;
    evs.delete();
    u_dais_dec_model.taken.delete();
    bumps = 0;
  endtask : begin_scen
  // wait, bounded, until n ops reached execute
  task automatic settle(input int n);
    int k;
    for (k = 0; k < 80 && evs.size() < n; k++) @(posedge clk);
    if (evs.size() < n) begin
      bad_count++;
      $display("[ERR] %0t wait ran out", $time);
      tally_and_finish();
    end
    repeat (6) @(posedge clk);
  endtask : settle
  // multiply alone, then an alu and a shift behind it
  task automatic mul_scen();
    dais_ev_type m1;
    dais_ev_type m2;
    dais_ev_type m3;
    dais_ev_type sh;
    dais_ev_type al;
    begin_scen();
    u_dais_dec_model.push(op(CLS_MUL, 1, 2), '0);
    u_dais_dec_model.push(op(CLS_ALU, 5, 6), op(CLS_SHIFT, 3, 4));
    settle(5);
    m1 = ev(CLS_MUL, 2'h1, 0);
    m2 = ev(CLS_MUL, 2'h2, 0);
    m3 = ev(CLS_MUL, 2'h3, 0);
    sh = ev(CLS_SHIFT, 2'h0, 0);
    al = ev(CLS_ALU, 2'h0, 0);
    check(m1.c - u_dais_dec_model.taken[0], 4);
    check(m1.u, `DAIS_UNIT_X);
    check(m2.c - m1.c, 1);
    check(m3.c - m2.c, 1);
    check(sh.u, `DAIS_UNIT_X);
    check(sh.c > m3.c, 1);
    check(al.u, `DAIS_UNIT_Y);
  endtask : mul_scen
  // load-immediate feeding an alu at once
  task automatic limm_scen();
    begin_scen();
    u_dais_dec_model.push(op(CLS_LIMM, -1, 1), op(CLS_ALU, 1, 2));
    settle(1);
    check(ev(CLS_ALU, 2'h0, 0).c - u_dais_dec_model.taken[0], 3);
    check(evs.size(), 1);
  endtask : limm_scen
  // alu result into a load address, then loads back to back
  task automatic lbyp_scen();
    begin_scen();
    u_dais_dec_model.push(op(CLS_ALU, -1, 2), op(CLS_LOAD, 2, 3));
    u_dais_dec_model.push(op(CLS_LOAD, -1, 4), op(CLS_LOAD, -1, 5));
    settle(4);
    check(ev(CLS_LOAD, 2'h0, 0).c - ev(CLS_ALU, 2'h0, 0).c, 1);
    check(ev(CLS_LOAD, 2'h0, 1).c - ev(CLS_LOAD, 2'h0, 0).c, 1);
    check(ev(CLS_LOAD, 2'h0, 2).c - ev(CLS_LOAD, 2'h0, 1).c, 1);
  endtask : lbyp_scen
  // dependent loads, a bumped alu and an independent op passing it
  task automatic bump_scen();
    dais_ev_type l1;
    dais_ev_type al;
    begin_scen();
    u_dais_dec_model.push(op(CLS_LOAD, -1, 6), op(CLS_LOAD, 6, 7));
    u_dais_dec_model.push(op(CLS_ALU, 7, 1), '0);
    u_dais_dec_model.push(op(CLS_SHIFT, -1, 2), '0);
    settle(4);
    l1 = ev(CLS_LOAD, 2'h0, 1);
    al = ev(CLS_ALU, 2'h0, 0);
    check(l1.c - ev(CLS_LOAD, 2'h0, 0).c, 2);
    check(bumps > 0, 1);
    check(al.c - l1.c, 2);
    check(ev(CLS_SHIFT, 2'h0, 0).c < al.c, 1);
  endtask : bump_scen
  // store then a load that depends on it in memory
  task automatic fwd_scen();
    dais_dec_type ld;
    begin_scen();
    ld = op(CLS_LOAD, -1, 3);
    ld.memDep = 1'h1;
    u_dais_dec_model.push(op(CLS_STORE, -1, -1), ld);
    settle(2);
    check(ev(CLS_STORE, 2'h0, 0).u, `DAIS_UNIT_S);
    check(ev(CLS_LOAD, 2'h0, 0).c - ev(CLS_STORE, 2'h0, 0).c, 1);
  endtask : fwd_scen
  // reset, a short enable gap, then the scenarios
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'h1;
    @(posedge clk);
    ce <= 1'h0;
    repeat (2) @(posedge clk);
    ce <= 1'h1;
    @(posedge clk);
    mul_scen();
    limm_scen();
    lbyp_scen();
    bump_scen();
    fwd_scen();
    tally_and_finish();
  end
endmodule : dais_issue_sched_bench
`default_nettype wire
